// ===== shared/ecsel_pkg.sv
package ecsel_pkg;

   localparam int ECSEL_NUM_CH     = 16;
   localparam int ECSEL_CH_CODE_W  = 6;
   localparam int ECSEL_IRQ_CODE_W = 5;
   localparam int ECSEL_NUM_IRQ    = 12;
   localparam int ECSEL_NUM_PINS   = 6;

   // Register byte addresses
   localparam logic [31:0] CH_SEL_A_ADDR     = 32'h01a0ff00;
   localparam logic [31:0] CH_SEL_B_ADDR     = 32'h01a0ff04;
   localparam logic [31:0] CH_SEL_C_ADDR     = 32'h01a0ff0c;
   localparam logic [31:0] IRQ_SEL_HIGH_ADDR = 32'h019c0000;
   localparam logic [31:0] IRQ_SEL_LOW_ADDR  = 32'h019c0004;
   localparam logic [31:0] CTRL_ADDR         = 32'h01a0ff20;
   localparam logic [31:0] PIN_STATUS_ADDR   = 32'h01a0ff24;

   // Writable bit masks; all other bits read as zero
   localparam logic [31:0] CH_SEL_MASK  = 32'h3f3f3f3f;
   localparam logic [31:0] IRQ_SEL_MASK = 32'h7fff7fff;
   localparam logic [31:0] CTRL_MASK    = 32'h0000010f;

   // Reset values
   localparam logic [31:0] CH_SEL_A_RST     = 32'h03020100;
   localparam logic [31:0] CH_SEL_B_RST     = 32'h07060504;
   localparam logic [31:0] CH_SEL_C_RST     = 32'h0f0e0d0c;
   localparam logic [31:0] IRQ_SEL_LOW_RST  = 32'h250718a4;
   localparam logic [31:0] IRQ_SEL_HIGH_RST = 32'h08202d43;
   localparam logic [31:0] CTRL_RST         = 32'h00000100;

   // Control fields
   localparam int CTRL_POL_LSB  = 0;
   localparam int CTRL_POL_W    = 4;
   localparam int CTRL_MODE_BIT = 8;

   // Channel selector field layout
   localparam int CH_PER_REG    = 4;
   localparam int CH_FIELD_STEP = 8;

   // Interrupt selector field layout, six lines per register
   localparam int IRQ_PER_REG = 6;
   localparam int IRQ_FIELD_LSB [0:5] = '{0, 5, 10, 16, 21, 26};

   // Chaining channels
   localparam int         CHAIN_FIRST_CH  = 8;
   localparam int         CHAIN_NUM       = 4;
   localparam logic [3:0] CHAIN_CODE_BASE = 4'h8;

   // Pin numbers carried by the pin port, lowest entry first
   localparam int PIN_NUM [0:5] = '{0, 2, 4, 5, 6, 7};
   localparam int POL_FIRST_PIN = 4;

   // Channel selector codes
   localparam logic [5:0] CH_CODE_HOST    = 6'h00;
   localparam logic [5:0] CH_CODE_TIMER_A = 6'h01;
   localparam logic [5:0] CH_CODE_TIMER_B = 6'h02;
   localparam logic [5:0] CH_CODE_REFRESH = 6'h03;
   localparam logic [5:0] CH_CODE_PIN4    = 6'h04;
   localparam logic [5:0] CH_CODE_PIN5    = 6'h05;
   localparam logic [5:0] CH_CODE_PIN6    = 6'h06;
   localparam logic [5:0] CH_CODE_PIN7    = 6'h07;
   localparam logic [5:0] CH_CODE_PIN2    = 6'h0a;
   localparam logic [5:0] CH_CODE_SA_TX   = 6'h0c;
   localparam logic [5:0] CH_CODE_SA_RX   = 6'h0d;
   localparam logic [5:0] CH_CODE_SB_TX   = 6'h0e;
   localparam logic [5:0] CH_CODE_SB_RX   = 6'h0f;

   // Interrupt selector codes
   localparam logic [4:0] IRQ_CODE_HOST    = 5'h00;
   localparam logic [4:0] IRQ_CODE_TIMER_A = 5'h01;
   localparam logic [4:0] IRQ_CODE_TIMER_B = 5'h02;
   localparam logic [4:0] IRQ_CODE_REFRESH = 5'h03;
   localparam logic [4:0] IRQ_CODE_PIN4    = 5'h04;
   localparam logic [4:0] IRQ_CODE_PIN5    = 5'h05;
   localparam logic [4:0] IRQ_CODE_PIN6    = 5'h06;
   localparam logic [4:0] IRQ_CODE_PIN7    = 5'h07;
   localparam logic [4:0] IRQ_CODE_XFER    = 5'h08;
   localparam logic [4:0] IRQ_CODE_EMU_DT  = 5'h09;
   localparam logic [4:0] IRQ_CODE_EMU_RX  = 5'h0a;
   localparam logic [4:0] IRQ_CODE_EMU_TX  = 5'h0b;
   localparam logic [4:0] IRQ_CODE_SA_TX   = 5'h0c;
   localparam logic [4:0] IRQ_CODE_SA_RX   = 5'h0d;
   localparam logic [4:0] IRQ_CODE_SB_TX   = 5'h0e;
   localparam logic [4:0] IRQ_CODE_SB_RX   = 5'h0f;
   localparam logic [4:0] IRQ_CODE_PIN0    = 5'h10;

   typedef struct packed {
      logic host_to_cpu_irq;
      logic timer_a_irq;
      logic timer_b_irq;
      logic refresh_timer_irq;
      logic transfer_complete_irq;
      logic emulation_transfer_event;
      logic emulation_rx_event;
      logic emulation_tx_event;
      logic serial_a_tx_irq;
      logic serial_a_rx_irq;
      logic serial_b_tx_irq;
      logic serial_b_rx_irq;
      logic serial_a_tx_event;
      logic serial_a_rx_event;
      logic serial_b_tx_event;
      logic serial_b_rx_event;
   } ecsel_events_s;

   typedef struct packed {
      logic       valid;
      logic [3:0] code;
   } ecsel_chain_s;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } ecsel_apb_req_s;

endpackage

// ===== verilog/ecsel_pin_edge.sv
`timescale 1ns/100ps
`default_nettype none

module ecsel_pin_edge
   import ecsel_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic pin,
   input  wire logic falling_sel,
   input  wire logic pin_usable,
   output logic      level_r,
   output logic      event_r
);

   logic meta_r;
   logic prev_r;

   // Second stage is the only reader of the first
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_r  <= 1'b0;
         level_r <= 1'b0;
         prev_r  <= 1'b0;
      end
      else
      begin
         meta_r  <= pin;
         level_r <= meta_r;
         prev_r  <= level_r;
      end
   end

   // Edge taken from settled samples, so a polarity change makes no edge
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         event_r <= 1'b0;
      else if (falling_sel)
         event_r <= pin_usable & prev_r & ~level_r;
      else
         event_r <= pin_usable & ~prev_r & level_r;
   end

endmodule

`default_nettype wire

// ===== verilog/ecsel_top.sv
// Functional notes
// - Five-bit interrupt codes pick interrupt sources
// - Pins 0 and 4-7 produce pin interrupt events
// - Pin events edge detected, per-pin polarity on pins 4-7; pins 0 and 2 rising only
// - Sixteen channels, twelve peripheral-triggered
// - Channels 8-11 fire on completion codes only
// - Fixed mode: channel number selects its event
// - Programmable mode: field selects channel event
// - Six-bit fields at bytes, three registers
// - Fields reset to own channel number
// - Channel codes decode; unlisted codes reserved
// - Channel selectors at three fixed addresses
// - Interrupt selectors at two fixed addresses
// - Gap bits read zero, ignore writes
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module ecsel_top
   import ecsel_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire ecsel_apb_req_s       apb_req,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire ecsel_events_s        periph,
   input  wire ecsel_chain_s         chain_done,
   input  wire logic [5:0]           event_pins,
   input  wire logic [7:0]           pin_enable_bits,
   input  wire logic [7:0]           pin_direction_bits,
   output logic [ECSEL_NUM_CH-1:0]   chan_event,
   output logic [ECSEL_NUM_IRQ-1:0]  irq_line
);

   logic [31:0]              ch_sel_r [0:2];
   logic [31:0]              irq_sel_r [0:1];
   logic [31:0]              ctrl_r;
   logic [31:0]              prdata_r;
   logic                     pready_r;
   logic                     pslverr_r;
   logic [ECSEL_NUM_CH-1:0]  chan_event_r;
   logic [ECSEL_NUM_IRQ-1:0] irq_line_r;
   logic [ECSEL_NUM_CH-1:0]  chan_hit;
   logic [ECSEL_NUM_IRQ-1:0] irq_hit;
   logic [7:0]               pin_evt;
   logic [5:0]               pin_level;
   logic [5:0]               pin_evt_raw;
   logic                     prog_mode;
   logic [CTRL_POL_W-1:0]    edge_polarity_bits;
   logic                     setup_phase;
   logic                     wr_commit;
   logic [31:0]              rd_nxt;
   logic                     err_nxt;

   assign prog_mode          = ctrl_r[CTRL_MODE_BIT];
   assign edge_polarity_bits = ctrl_r[CTRL_POL_LSB +: CTRL_POL_W];

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign chan_event = chan_event_r;
   assign irq_line   = irq_line_r;

   // Pin sampling and edge detection

   genvar p;
   generate
      for (p = 0; p < ECSEL_NUM_PINS; p++)
      begin : g_pin
         localparam int PN = PIN_NUM[p];
         logic pol;
         logic usable;

         if (PN >= POL_FIRST_PIN)
         begin : g_pol
            assign pol = edge_polarity_bits[PN - POL_FIRST_PIN];
         end
         else
         begin : g_rise
            assign pol = 1'b0;
         end

         // Direction bit high means output; only inputs raise events
         assign usable = pin_enable_bits[PN] & ~pin_direction_bits[PN];

         ecsel_pin_edge u_edge
         (
            .clk         (clk),
            .reset       (reset),
            .pin         (event_pins[p]),
            .falling_sel (pol),
            .pin_usable  (usable),
            .level_r     (pin_level[p]),
            .event_r     (pin_evt_raw[p])
         );
      end
   endgenerate

   // Pins 1 and 3 carry no event source here
   always_comb
   begin
      pin_evt = 8'h00;
      for (int i = 0; i < ECSEL_NUM_PINS; i++)
         pin_evt[PIN_NUM[i]] = pin_evt_raw[i];
   end

   // Decoders

   function automatic logic chan_src(input logic [5:0] code,
                                     input ecsel_events_s ev,
                                     input logic [7:0] gp);
      logic hit;
      hit = 1'b0;
      case (code)
         CH_CODE_HOST:    hit = ev.host_to_cpu_irq;
         CH_CODE_TIMER_A: hit = ev.timer_a_irq;
         CH_CODE_TIMER_B: hit = ev.timer_b_irq;
         CH_CODE_REFRESH: hit = ev.refresh_timer_irq;
         CH_CODE_PIN4:    hit = gp[4];
         CH_CODE_PIN5:    hit = gp[5];
         CH_CODE_PIN6:    hit = gp[6];
         CH_CODE_PIN7:    hit = gp[7];
         CH_CODE_PIN2:    hit = gp[2];
         CH_CODE_SA_TX:   hit = ev.serial_a_tx_event;
         CH_CODE_SA_RX:   hit = ev.serial_a_rx_event;
         CH_CODE_SB_TX:   hit = ev.serial_b_tx_event;
         CH_CODE_SB_RX:   hit = ev.serial_b_rx_event;
         default:         hit = 1'b0;
      endcase
      return hit;
   endfunction

   function automatic logic irq_src(input logic [4:0] code,
                                    input ecsel_events_s ev,
                                    input logic [7:0] gp);
      logic hit;
      hit = 1'b0;
      case (code)
         IRQ_CODE_HOST:    hit = ev.host_to_cpu_irq;
         IRQ_CODE_TIMER_A: hit = ev.timer_a_irq;
         IRQ_CODE_TIMER_B: hit = ev.timer_b_irq;
         IRQ_CODE_REFRESH: hit = ev.refresh_timer_irq;
         IRQ_CODE_PIN4:    hit = gp[4];
         IRQ_CODE_PIN5:    hit = gp[5];
         IRQ_CODE_PIN6:    hit = gp[6];
         IRQ_CODE_PIN7:    hit = gp[7];
         IRQ_CODE_XFER:    hit = ev.transfer_complete_irq;
         IRQ_CODE_EMU_DT:  hit = ev.emulation_transfer_event;
         IRQ_CODE_EMU_RX:  hit = ev.emulation_rx_event;
         IRQ_CODE_EMU_TX:  hit = ev.emulation_tx_event;
         IRQ_CODE_SA_TX:   hit = ev.serial_a_tx_irq;
         IRQ_CODE_SA_RX:   hit = ev.serial_a_rx_irq;
         IRQ_CODE_SB_TX:   hit = ev.serial_b_tx_irq;
         IRQ_CODE_SB_RX:   hit = ev.serial_b_rx_irq;
         IRQ_CODE_PIN0:    hit = gp[0];
         default:          hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Channel routing

   genvar ch;
   generate
      for (ch = 0; ch < ECSEL_NUM_CH; ch++)
      begin : g_ch
         if (ch >= CHAIN_FIRST_CH && ch < CHAIN_FIRST_CH + CHAIN_NUM)
         begin : g_chain
            localparam logic [3:0] MY_CODE =
               CHAIN_CODE_BASE + 4'(ch - CHAIN_FIRST_CH);
            // No field and no peripheral path for these channels
            assign chan_hit[ch] = chain_done.valid &
                                  (chain_done.code == MY_CODE);
         end
         else
         begin : g_periph
            localparam int RIDX = (ch < CHAIN_FIRST_CH) ?
                                  ch / CH_PER_REG : 2;
            localparam int LSB  = (ch % CH_PER_REG) * CH_FIELD_STEP;
            logic [5:0] eff_code;
            // Fixed mode ignores the field and uses the channel number
            assign eff_code = prog_mode ?
                              ch_sel_r[RIDX][LSB +: ECSEL_CH_CODE_W] :
                              6'(ch);
            assign chan_hit[ch] = chan_src(eff_code, periph,
                                           pin_evt);
         end
      end
   endgenerate

   // Interrupt line routing, lines 4 to 15

   genvar ln;
   generate
      for (ln = 0; ln < ECSEL_NUM_IRQ; ln++)
      begin : g_irq
         localparam int RIDX = ln / IRQ_PER_REG;
         localparam int LSB  = IRQ_FIELD_LSB[ln % IRQ_PER_REG];
         assign irq_hit[ln] =
            irq_src(irq_sel_r[RIDX][LSB +: ECSEL_IRQ_CODE_W],
                    periph, pin_evt);
      end
   endgenerate

   // One cycle of latency keeps both outputs on flip-flops
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         chan_event_r <= '0;
      else
         chan_event_r <= chan_hit;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         irq_line_r <= '0;
      else
         irq_line_r <= irq_hit;
   end

   // APB slave: no wait states, read data registered in setup

   assign setup_phase = apb_req.psel & ~apb_req.penable & ~pready_r;
   assign wr_commit   = apb_req.psel & apb_req.penable & pready_r &
                        apb_req.pwrite;

   always_comb
   begin
      rd_nxt  = 32'h00000000;
      err_nxt = 1'b0;
      case (apb_req.paddr)
         CH_SEL_A_ADDR:     rd_nxt = ch_sel_r[0];
         CH_SEL_B_ADDR:     rd_nxt = ch_sel_r[1];
         CH_SEL_C_ADDR:     rd_nxt = ch_sel_r[2];
         IRQ_SEL_LOW_ADDR:  rd_nxt = irq_sel_r[0];
         IRQ_SEL_HIGH_ADDR: rd_nxt = irq_sel_r[1];
         CTRL_ADDR:         rd_nxt = ctrl_r;
         PIN_STATUS_ADDR:   rd_nxt = {26'h0000000, pin_level};
         default:           err_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end
      else
      begin
         pready_r  <= setup_phase;
         pslverr_r <= setup_phase & err_nxt;
         // Data read zero outside the answering cycle
         prdata_r  <= (setup_phase & ~apb_req.pwrite) ? rd_nxt :
                      32'h00000000;
      end
   end

   // Register writes; masks drop the gap bits
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ch_sel_r[0] <= CH_SEL_A_RST;
         ch_sel_r[1] <= CH_SEL_B_RST;
         ch_sel_r[2] <= CH_SEL_C_RST;
      end
      else if (wr_commit)
      begin
         case (apb_req.paddr)
            CH_SEL_A_ADDR:
               ch_sel_r[0] <= apb_req.pwdata & CH_SEL_MASK;
            CH_SEL_B_ADDR:
               ch_sel_r[1] <= apb_req.pwdata & CH_SEL_MASK;
            CH_SEL_C_ADDR:
               ch_sel_r[2] <= apb_req.pwdata & CH_SEL_MASK;
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         irq_sel_r[0] <= IRQ_SEL_LOW_RST;
         irq_sel_r[1] <= IRQ_SEL_HIGH_RST;
      end
      else if (wr_commit)
      begin
         case (apb_req.paddr)
            IRQ_SEL_LOW_ADDR:
               irq_sel_r[0] <= apb_req.pwdata & IRQ_SEL_MASK;
            IRQ_SEL_HIGH_ADDR:
               irq_sel_r[1] <= apb_req.pwdata & IRQ_SEL_MASK;
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ctrl_r <= CTRL_RST;
      else if (wr_commit && apb_req.paddr == CTRL_ADDR)
         ctrl_r <= apb_req.pwdata & CTRL_MASK;
   end

endmodule

`default_nettype wire

// ===== dv/ecsel_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

module ecsel_top_chk
   import ecsel_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    reset,
   input wire ecsel_apb_req_s          apb_req,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire ecsel_events_s           periph,
   input wire ecsel_chain_s            chain_done,
   input wire logic [5:0]              event_pins,
   input wire logic [7:0]              pin_enable_bits,
   input wire logic [7:0]              pin_direction_bits,
   input wire logic [ECSEL_NUM_CH-1:0] chan_event,
   input wire logic [ECSEL_NUM_IRQ-1:0] irq_line
);
   logic [3:0] chain_exp_r;
   logic [5:0] pins_r;
   logic [3:0] quiet_r;
   logic       mapped;
   logic       ch_reg;

   assign mapped = apb_req.paddr inside {CH_SEL_A_ADDR, CH_SEL_B_ADDR,
      CH_SEL_C_ADDR, IRQ_SEL_HIGH_ADDR, IRQ_SEL_LOW_ADDR, CTRL_ADDR,
      PIN_STATUS_ADDR};
   assign ch_reg = apb_req.paddr inside {CH_SEL_A_ADDR, CH_SEL_B_ADDR,
      CH_SEL_C_ADDR};

   always_ff @(posedge clk or posedge reset)
      if (reset)
         chain_exp_r <= 4'h0;
      else if (chain_done.valid && chain_done.code[3:2] == 2'b10)
         chain_exp_r <= 4'h1 << chain_done.code[1:0];
      else
         chain_exp_r <= 4'h0;

   always_ff @(posedge clk or posedge reset)
      if (reset)
         pins_r <= 6'h00;
      else
         pins_r <= event_pins;

   // Pin events lag the pin by a few cycles, so only judge quiet spans
   always_ff @(posedge clk or posedge reset)
      if (reset)
         quiet_r <= 4'h0;
      else if (pins_r != event_pins)
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
         quiet_r <= quiet_r + 4'h1;

   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   a_ready_setup: assert property (apb_req.psel && !apb_req.penable
      |=> pready) else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (pready
      |-> $past(apb_req.psel && !apb_req.penable))
      else $error("ready without setup");
   a_err_map: assert property (pready |-> pslverr == !mapped)
      else $error("slave error does not match address map");
   a_rdata_idle: assert property (!(pready && !apb_req.pwrite)
      |-> prdata == 32'h0) else $error("read data outside read");
   a_gap_zero: assert property (pready && !apb_req.pwrite && ch_reg
      |-> (prdata & ~CH_SEL_MASK) == 32'h0) else $error("gap bits set");
   a_chain_map: assert property (chan_event[11:8] == chain_exp_r)
      else $error("chaining channel mismatch");
   a_chan_cause: assert property (quiet_r > 4'h6
      && (chan_event[7:0] != 8'h0 || chan_event[15:12] != 4'h0)
      |-> $past(periph) != 16'h0) else $error("channel event uncaused");
   a_irq_cause: assert property (quiet_r > 4'h6 && irq_line != 12'h0
      |-> $past(periph) != 16'h0) else $error("interrupt uncaused");
endmodule

bind ecsel_top ecsel_top_chk ecsel_top_chk_inst (.clk(clk), .reset(reset),
   .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .periph(periph), .chain_done(chain_done), .event_pins(event_pins),
   .pin_enable_bits(pin_enable_bits),
   .pin_direction_bits(pin_direction_bits), .chan_event(chan_event),
   .irq_line(irq_line));

`default_nettype wire

// ===== dv/ecsel_far_model.sv
`timescale 1ns/100ps
`default_nettype none

module ecsel_far_model
   import ecsel_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [4:0]  fire,
   input  wire logic [15:0] chan_event,
   output var ecsel_chain_s chain_done,
   output logic [7:0]       chain_cnt
);
   // Code is junk outside the pulse so a decoder must gate on valid
   always_ff @(posedge clk or posedge reset)
      if (reset)
         chain_done <= '0;
      else if (fire[4])
         chain_done <= '{valid: 1'b1, code: fire[3:0]};
      else
         chain_done <= '{valid: 1'b0, code: ~chain_done.code};

   always_ff @(posedge clk or posedge reset)
      if (reset)
         chain_cnt <= 8'h00;
      else
         chain_cnt <= chain_cnt + {7'h0, |chan_event[11:8]};
endmodule

`default_nettype wire

// ===== dv/ecsel_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ecsel_top_tb;
   import ecsel_pkg::*;
   logic           clk;
   logic           reset;
   ecsel_apb_req_s apb_req;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   ecsel_events_s  periph;
   ecsel_chain_s   chain_done;
   logic [5:0]     event_pins;
   logic [7:0]     pin_en;
   logic [7:0]     pin_dir;
   logic [15:0]    chan_event;
   logic [11:0]    irq_line;
   logic [4:0]     fire;
   logic [7:0]     chain_cnt;
   int             err_total;
   int             comparisons;
   logic [15:0]    def_ch [0:15] = '{16'h0001, 16'h0002, 16'h0004,
      16'h0008, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h1000, 16'h2000, 16'h4000, 16'h8000};
   logic [11:0]    def_irq [0:15] = '{12'h200, 12'h400, 12'h800, 12'h040,
      12'h010, 12'h020, 12'h080, 12'h100, 12'h0, 12'h0, 12'h0, 12'h0,
      12'h0, 12'h0, 12'h0, 12'h0};

   ecsel_top ecsel_top_inst (.clk(clk), .reset(reset), .apb_req(apb_req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph),
      .chain_done(chain_done), .event_pins(event_pins),
      .pin_enable_bits(pin_en), .pin_direction_bits(pin_dir),
      .chan_event(chan_event), .irq_line(irq_line));
   ecsel_far_model ecsel_far_model_inst (.clk(clk), .reset(reset),
      .fire(fire), .chan_event(chan_event), .chain_done(chain_done),
      .chain_cnt(chain_cnt));

   task automatic finish_test();
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      apb_req <= '0;
      chk({31'h0, n < 50}, 32'h1);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] x,
      input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask

   // Collects outputs over a span so pulse latency need not be exact
   task automatic watch(input int n, input logic [15:0] xc,
      input logic [11:0] xi);
      logic [15:0] c;
      logic [11:0] i;
      c = '0;
      i = '0;
      repeat (n)
      begin
         #1;
         c |= chan_event;
         i |= irq_line;
         @(posedge clk);
      end
      chk({16'h0, c}, {16'h0, xc});
      chk({20'h0, i}, {20'h0, xi});
   endtask

   task automatic ev(input ecsel_events_s x, input logic [15:0] xc,
      input logic [11:0] xi);
      @(posedge clk);
      periph <= x;
      @(posedge clk);
      periph <= '0;
      watch(3, xc, xi);
   endtask

   task automatic pin(input logic [5:0] v, input logic [15:0] xc,
      input logic [11:0] xi);
      @(posedge clk);
      event_pins <= v;
      watch(8, xc, xi);
   endtask

   task automatic t_reset();
      rd(CH_SEL_A_ADDR, 32'h03020100, 1'b0);
      rd(CH_SEL_B_ADDR, 32'h07060504, 1'b0);
      rd(CH_SEL_C_ADDR, 32'h0f0e0d0c, 1'b0);
      rd(IRQ_SEL_HIGH_ADDR, 32'h08202d43, 1'b0);
      rd(IRQ_SEL_LOW_ADDR, 32'h250718a4, 1'b0);
      rd(PIN_STATUS_ADDR, 32'h0, 1'b0);
      rd(CTRL_ADDR, CTRL_RST, 1'b0);
   endtask

   task automatic t_regs();
      wr(CH_SEL_A_ADDR, 32'hffffffff);
      rd(CH_SEL_A_ADDR, 32'h3f3f3f3f, 1'b0);
      wr(32'h01a0ff08, 32'hffffffff);
      rd(32'h01a0ff08, 32'h0, 1'b1);
      wr(IRQ_SEL_LOW_ADDR, 32'hffffffff);
      rd(IRQ_SEL_LOW_ADDR, 32'h7fff7fff, 1'b0);
      wr(IRQ_SEL_LOW_ADDR, IRQ_SEL_LOW_RST);
      wr(CH_SEL_A_ADDR, CH_SEL_A_RST);
   endtask

   task automatic t_map(input logic [31:0] ctrl, input logic [31:0] sela);
      wr(CTRL_ADDR, ctrl);
      wr(CH_SEL_A_ADDR, sela);
      for (int k = 0; k < 16; k++)
         ev(ecsel_events_s'(16'h8000 >> k), def_ch[k], def_irq[k]);
      wr(CTRL_ADDR, CTRL_RST);
      wr(CH_SEL_A_ADDR, CH_SEL_A_RST);
   endtask

   task automatic t_prog();
      wr(CH_SEL_A_ADDR, 32'h0f0f0f0f);
      ev(16'h0001, 16'h800f, 12'h000);
      wr(CH_SEL_A_ADDR, 32'h100b0908);
      ev(16'hffff, 16'hf000, 12'hff0);
      wr(CH_SEL_A_ADDR, CH_SEL_A_RST);
      // Second and third selectors steer their own channels only
      wr(CH_SEL_B_ADDR, 32'h0c0c0c0c);
      wr(CH_SEL_C_ADDR, 32'h01010101);
      ev(16'h4000, 16'hf002, 12'h400);
      ev(16'h0008, 16'h00f0, 12'h000);
      wr(CH_SEL_B_ADDR, CH_SEL_B_RST);
      wr(CH_SEL_C_ADDR, CH_SEL_C_RST);
      wr(IRQ_SEL_HIGH_ADDR, 32'h08202d4c);
      ev(16'h0080, 16'h0000, 12'h040);
      wr(IRQ_SEL_HIGH_ADDR, IRQ_SEL_HIGH_RST);
   endtask

   task automatic t_pins();
      @(posedge clk);
      pin_en <= 8'hf5;
      wr(CH_SEL_A_ADDR, 32'h0302010a);
      pin(6'h04, 16'h0010, 12'h001);
      pin(6'h00, 16'h0000, 12'h000);
      wr(CTRL_ADDR, 32'h00000101);
      pin(6'h04, 16'h0000, 12'h000);
      pin(6'h00, 16'h0010, 12'h001);
      @(posedge clk);
      pin_dir <= 8'hf0;
      pin(6'h04, 16'h0000, 12'h000);
      pin(6'h00, 16'h0000, 12'h000);
      @(posedge clk);
      pin_dir <= 8'h00;
      wr(IRQ_SEL_LOW_ADDR, 32'h250718b0);
      pin(6'h03, 16'h0001, 12'h001);
      rd(PIN_STATUS_ADDR, 32'h00000003, 1'b0);
      wr(IRQ_SEL_LOW_ADDR, IRQ_SEL_LOW_RST);
      wr(CH_SEL_A_ADDR, CH_SEL_A_RST);
      wr(CTRL_ADDR, CTRL_RST);
   endtask

   task automatic t_chain();
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clk);
         fire <= {1'b1, 4'(k)};
         @(posedge clk);
         fire <= 5'h0;
         watch(4, (k inside {[8:11]}) ? 16'(32'h1 << k) : 16'h0, 12'h0);
      end
      chk({24'h0, chain_cnt}, 32'h4);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      finish_test();
   end

   initial
   begin
      err_total = 0;
      comparisons = 0;
      apb_req = '0;
      periph = '0;
      fire = 5'h0;
      event_pins = 6'h00;
      pin_en = 8'h00;
      pin_dir = 8'h00;
      reset = 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_regs();
      t_map(CTRL_RST, CH_SEL_A_RST);
      t_map(32'h0, 32'h0f0f0f0f);
      t_prog();
      t_pins();
      t_chain();
      finish_test();
   end
endmodule

`default_nettype wire
